// >>> bench/redundant_lane_path_select_tb_top.sv
// testbench for the lane path select block
`timescale 1ns/1ps
`default_nettype none
module redundant_lane_path_select_tb_top;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, drl = 1'b0;
    logic side = 1'b1, ret = 1'b0, idl = 1'b0, sa, ra;
    rlps_pkg::rlps_word_t xtx, arx = '0, brx = {32'hFFFF0000, 4'h9};
    rlps_pkg::rlps_word_t xrx, atx, btx, c_x, c_a, c_b, idw, ea, eb;
    int errors = 0, checks = 0, cyc = 0;
    initial forever #20 sys_clk_i = ~sys_clk_i;
    rlps_mac_model u_rlps_mac_model (.clk_i(sys_clk_i), .xgmii_tx_o(xtx));
    rlps_path_select u_rlps_path_select (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .device_reset_low_i(drl), .side_select_i(side),
        .retimer_mode_enable_i(ret), .idle_enable_i(idl),
        .xgmii_tx_i(xtx), .chan_a_rx_i(arx), .chan_b_rx_i(brx),
        .xgmii_rx_o(xrx), .chan_a_tx_o(atx), .chan_b_tx_o(btx),
        .side_a_active_o(sa), .retimer_active_o(ra));
    // ======== capture and timeout
    always @(posedge sys_clk_i) begin
        c_x <= xtx;
        c_a <= arx;
        c_b <= brx;
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            report_and_stop();
        end
    end
    // receive words differ every cycle so a stale path shows
    always @(negedge sys_clk_i) begin
        arx.data <= arx.data + 32'h00010003;
        arx.ctrl <= ~arx.ctrl;
        brx.data <= brx.data - 32'h00020005;
        brx.ctrl <= brx.ctrl ^ 4'h5;
    end
    // ======== compare tasks
    task automatic cmp_w(input rlps_pkg::rlps_word_t g, e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t word %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic g, e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic check_paths();
        ea = ret ? c_b : (idl && !side) ? idw : c_x;
        eb = ret ? c_a : (idl && side) ? idw : c_x;
        cmp_w(xrx, side ? c_a : c_b);
        cmp_w(atx, ea);
        cmp_w(btx, eb);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ======== main sequence
    initial begin
        idw = {rlps_pkg::IDLE_DATA, rlps_pkg::IDLE_CTRL};
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'b0;
        repeat (rlps_pkg::RST_HOLD_CYC) @(negedge sys_clk_i);
        cmp_w(xrx, idw);
        cmp_w(atx, idw);
        cmp_b(sa, 1'b1);
        cmp_b(ra, 1'b0);
        drl = 1'b1;
        for (int m = 0; m < 8; m++) begin
            {side, ret, idl} = 3'(m);
            // mode pins need the synchroniser to settle first
            repeat (8) @(negedge sys_clk_i);
            cmp_b(sa, side);
            cmp_b(ra, ret);
            repeat (3) begin
                @(negedge sys_clk_i);
                check_paths();
            end
        end
        drl = 1'b0;
        // pin passes three stages and the settled register before reset
        repeat (6) @(negedge sys_clk_i);
        cmp_w(atx, idw);
        cmp_w(btx, idw);
        cmp_w(xrx, idw);
        cmp_b(ra, 1'b0);
        cmp_b(sa, 1'b1);
        drl = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        check_paths();
        report_and_stop();
    end
endmodule // redundant_lane_path_select_tb_top
`default_nettype wire

// >>> bench/rlps_mac_model.sv
// mac side model driving the xgmii transmit word
`timescale 1ns/1ps
`default_nettype none
module rlps_mac_model (
    input  wire logic                clk_i,
    output var rlps_pkg::rlps_word_t xgmii_tx_o
);
    // new word each falling edge, held a full cycle for both edges
    initial begin
        xgmii_tx_o = {32'h12345678, 4'h3};
        forever begin
            @(negedge clk_i);
            xgmii_tx_o.data <= xgmii_tx_o.data + 32'h01010107;
            xgmii_tx_o.ctrl <= xgmii_tx_o.ctrl + 4'h5;
        end
    end
endmodule // rlps_mac_model
`default_nettype wire

// >>> include/rlps_pkg.sv
// package for the redundant lane path select block
`default_nettype none
package rlps_pkg;
    localparam int DATA_W       = 32;
    localparam int CTRL_W       = 4;
    // xgmii idle character and control pattern
    localparam logic [31:0] IDLE_DATA = 32'h07070707;
    localparam logic [3:0]  IDLE_CTRL = 4'hF;
    // reset hold on the chip reset pin, in microseconds
    localparam int RST_HOLD_US  = 10;
    localparam int CLK_MHZ      = 25;
    localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  ctrl;
    } rlps_word_t;
endpackage
`default_nettype wire

// >>> rtl/rlps_path_select.sv
// steering of xgmii and xaui words between channels a and b
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - side select high puts channel a receive on xgmii receive
// - side select low puts channel b receive on xgmii receive
// - side select picks the channel shown on xgmii receive
// - retimer mode loops a receive to b transmit and b to a
// - retimer off, idle high: non-selected transmitter sends idle codes
// - retimer off, idle low: both transmitters carry xgmii transmit data
// - idle level ignored while retimer mode is on
// - low chip reset reinitialises the mode and output registers, not the synchronisers
module rlps_path_select (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire logic               device_reset_low_i,
    input  wire logic               side_select_i,
    input  wire logic               retimer_mode_enable_i,
    input  wire logic               idle_enable_i,
    input  wire rlps_pkg::rlps_word_t xgmii_tx_i,
    input  wire rlps_pkg::rlps_word_t chan_a_rx_i,
    input  wire rlps_pkg::rlps_word_t chan_b_rx_i,
    output var rlps_pkg::rlps_word_t  xgmii_rx_o,
    output var rlps_pkg::rlps_word_t  chan_a_tx_o,
    output var rlps_pkg::rlps_word_t  chan_b_tx_o,
    output logic                    side_a_active_o,
    output logic                    retimer_active_o
);
    // ==========================================================
    // reset and pin synchronisers
    // ==========================================================
    logic [2:0] device_reset_low_sync_reg;
    logic [2:0] sel_sync_reg;
    logic [2:0] ret_sync_reg;
    logic [2:0] idl_sync_reg;
    logic       dev_rst_reg;
    logic       sel_reg;
    logic       ret_reg;
    logic       idl_reg;
    logic       any_rst;

    // chip reset pin is asynchronous to our clock, so it is sampled too
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            device_reset_low_sync_reg <= rlps_pkg::SYNC_RESET;
        end else begin
            device_reset_low_sync_reg <= {device_reset_low_sync_reg[1:0], device_reset_low_i};
        end
    end

    // a pin level counts once stages two and three agree, so a one-cycle
    // glitch on the chip reset pin cannot reach the data paths
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dev_rst_reg <= 1'b1;
        end else if (device_reset_low_sync_reg[1] == device_reset_low_sync_reg[2]) begin
            dev_rst_reg <= !device_reset_low_sync_reg[2];
        end
    end

    assign any_rst = rst_i || dev_rst_reg;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel_sync_reg <= rlps_pkg::SYNC_RESET;
            ret_sync_reg <= rlps_pkg::SYNC_RESET;
            idl_sync_reg <= rlps_pkg::SYNC_RESET;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], side_select_i};
            ret_sync_reg <= {ret_sync_reg[1:0], retimer_mode_enable_i};
            idl_sync_reg <= {idl_sync_reg[1:0], idle_enable_i};
        end
    end

    // a level change counts only once stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (any_rst) begin
            sel_reg <= 1'b1;
            ret_reg <= 1'b0;
            idl_reg <= 1'b0;
        end else begin
            if (sel_sync_reg[1] == sel_sync_reg[2]) begin
                sel_reg <= sel_sync_reg[2];
            end
            if (ret_sync_reg[1] == ret_sync_reg[2]) begin
                ret_reg <= ret_sync_reg[2];
            end
            if (idl_sync_reg[1] == idl_sync_reg[2]) begin
                idl_reg <= idl_sync_reg[2];
            end
        end
    end

    // ==========================================================
    // data steering
    // ==========================================================
    localparam rlps_pkg::rlps_word_t IDLE_WORD =
        '{data: rlps_pkg::IDLE_DATA, ctrl: rlps_pkg::IDLE_CTRL};

    rlps_pkg::rlps_word_t a_tx_next;
    rlps_pkg::rlps_word_t b_tx_next;

    always_comb begin
        if (ret_reg) begin
            a_tx_next = chan_b_rx_i;
            b_tx_next = chan_a_rx_i;
        end else if (idl_reg) begin
            a_tx_next = sel_reg ? xgmii_tx_i : IDLE_WORD;
            b_tx_next = sel_reg ? IDLE_WORD : xgmii_tx_i;
        end else begin
            a_tx_next = xgmii_tx_i;
            b_tx_next = xgmii_tx_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (any_rst) begin
            xgmii_rx_o  <= IDLE_WORD;
            chan_a_tx_o <= IDLE_WORD;
            chan_b_tx_o <= IDLE_WORD;
        end else begin
            xgmii_rx_o  <= sel_reg ? chan_a_rx_i : chan_b_rx_i;
            chan_a_tx_o <= a_tx_next;
            chan_b_tx_o <= b_tx_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (any_rst) begin
            side_a_active_o  <= 1'b1;
            retimer_active_o <= 1'b0;
        end else begin
            side_a_active_o  <= sel_reg;
            retimer_active_o <= ret_reg;
        end
    end

    // ==========================================================
    // checks: receive path and status flags
    // ==========================================================
    // the sampled reset term in each antecedent drops the edge at which
    // reset falls, since that edge still loads the reset values
    sel_a_path_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && sel_reg)
        |=> xgmii_rx_o == $past(chan_a_rx_i))
        else $error("side a not on xgmii receive");
    sel_b_path_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && !sel_reg)
        |=> xgmii_rx_o == $past(chan_b_rx_i))
        else $error("side b not on xgmii receive");
    side_flag_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) !any_rst
        |=> side_a_active_o == $past(sel_reg))
        else $error("side flag out of step");
    ret_flag_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) !any_rst
        |=> retimer_active_o == $past(ret_reg))
        else $error("retimer flag out of step");

    // ==========================================================
    // checks: transmit paths
    // ==========================================================
    retimer_x_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && ret_reg)
        |=> chan_b_tx_o == $past(chan_a_rx_i)
            && chan_a_tx_o == $past(chan_b_rx_i))
        else $error("retimer cross connect broken");
    idle_ins_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && !ret_reg && idl_reg && sel_reg)
        |=> chan_b_tx_o == IDLE_WORD
            && chan_a_tx_o == $past(xgmii_tx_i))
        else $error("idle not on non-selected side");
    idle_side_b_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && !ret_reg && idl_reg && !sel_reg)
        |=> chan_a_tx_o == IDLE_WORD
            && chan_b_tx_o == $past(xgmii_tx_i))
        else $error("idle not on side a transmitter");
    both_tx_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && !ret_reg && !idl_reg)
        |=> chan_a_tx_o == $past(xgmii_tx_i)
            && chan_b_tx_o == $past(xgmii_tx_i))
        else $error("transmit data not on both sides");
    idle_ign_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && ret_reg && idl_reg)
        |=> chan_a_tx_o == $past(chan_b_rx_i)
            && chan_b_tx_o == $past(chan_a_rx_i))
        else $error("idle level leaked into retimer");

    // ==========================================================
    // checks: resets and pin settling
    // ==========================================================
    reset_init_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) dev_rst_reg
        |=> xgmii_rx_o == IDLE_WORD && !retimer_active_o)
        else $error("chip reset did not reinitialise");
    flag_reset_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) dev_rst_reg
        |=> side_a_active_o && chan_a_tx_o == IDLE_WORD
            && chan_b_tx_o == IDLE_WORD)
        else $error("chip reset left a transmitter live");
    local_reset_a: assert property (@(posedge sys_clk_i)
        rst_i
        |=> xgmii_rx_o == IDLE_WORD && side_a_active_o
            && !retimer_active_o)
        else $error("local reset did not reinitialise");
    rst_filter_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (device_reset_low_sync_reg[1] != device_reset_low_sync_reg[2])
        |=> $stable(dev_rst_reg))
        else $error("chip reset taken before settling");
    rst_take_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (device_reset_low_sync_reg[1] == device_reset_low_sync_reg[2])
        |=> dev_rst_reg == !$past(device_reset_low_sync_reg[2]))
        else $error("settled chip reset level not taken");
    sync_hold_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && sel_sync_reg[1] != sel_sync_reg[2])
        |=> $stable(sel_reg))
        else $error("side select taken before settling");
    sel_take_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && sel_sync_reg[1] == sel_sync_reg[2])
        |=> sel_reg == $past(sel_sync_reg[2]))
        else $error("settled side select not taken");
    ret_settle_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && ret_sync_reg[1] != ret_sync_reg[2])
        |=> $stable(ret_reg))
        else $error("retimer mode taken before settling");
    idle_settle_a: assert property (@(posedge sys_clk_i)
        disable iff (any_rst) (!any_rst && idl_sync_reg[1] != idl_sync_reg[2])
        |=> $stable(idl_reg))
        else $error("idle level taken before settling");
endmodule // rlps_path_select
`default_nettype wire
